// file: verilog/oobx_pkg.sv
/*
  Constants, carrier structs and state types for the device-side
  out-of-band link initialisation block.
  Assumes a single 100 MHz core clock; all times are turned into cycles here.
*/
// Behaviour
// - a detected COMRESET holds the device in hardware reset before any handshake.
// - transmitted bursts last 160 Gen1 UI, gaps between them 480 Gen1 UI for COMINIT and 160 Gen1 UI for COMWAKE.
// - reset detection needs four consecutive bursts spaced about 320 ns.
// - a gap below 175 ns or above 525 ns invalidates reset detection.
// - after the last burst the line stays idle at least 525 ns.
// - device answers COMRESET end with COMINIT, or sends COMINIT on request.
// - COMINIT uses exactly the COMRESET burst and gap structure.
// - on detecting COMWAKE the device sends a six burst COMWAKE.
// - right after its COMWAKE the device streams ALIGN at its highest rate.
// - no host ALIGN within 2048 Gen1 dword times steps to the next lower rate.
// - no host ALIGN at the lowest rate puts the device into error.
// - locked and ready, the device sends SYNC to signal normal operation.
// - link is up only after three consecutive received non-ALIGN primitives.
// - each burst is four Gen1 ALIGN or four D24.3 dwords.
package oobx_pkg;

  // ==========================================================
  // clock and line unit
  localparam int    CLK_FS      = 10_000_000;
  localparam int    UI_FS       = 666_667;
  localparam int    NS_FS       = 1_000_000;
  localparam int    CNT_W       = 16;

  // ==========================================================
  // times in their own units
  localparam int    BURST_UI         = 160;
  localparam int    GAP_UI           = 480;
  localparam int    DWORD_UI         = 40;
  localparam int    RST_GAP_MIN_NS   = 175;
  localparam int    RST_GAP_MAX_NS   = 525;
  localparam int    QUIET_NS         = 525;
  localparam int    WAKE_GAP_MIN_NS  = 35;
  localparam int    WAKE_GAP_MAX_NS  = 174;
  localparam int    ALIGN_WAIT_DW    = 2048;

  // ==========================================================
  // counts
  localparam int    DET_BURSTS   = 4;
  localparam int    TX_BURSTS    = 6;
  localparam int    NONALIGN_RUN = 3;

  // ==========================================================
  // cycle counts; nominal lengths round to nearest, limits round inward
  localparam logic [CNT_W-1:0] BURST_CYC =
    CNT_W'((BURST_UI * UI_FS + CLK_FS / 2) / CLK_FS);
  localparam logic [CNT_W-1:0] GAP_CYC =
    CNT_W'((GAP_UI * UI_FS + CLK_FS / 2) / CLK_FS);
  // wake gap is one burst long
  localparam logic [CNT_W-1:0] WAKE_GAP_CYC = BURST_CYC;
  localparam logic [CNT_W-1:0] RST_GAP_MIN_CYC =
    CNT_W'((RST_GAP_MIN_NS * NS_FS + CLK_FS - 1) / CLK_FS);
  localparam logic [CNT_W-1:0] RST_GAP_MAX_CYC =
    CNT_W'((RST_GAP_MAX_NS * NS_FS) / CLK_FS);
  localparam logic [CNT_W-1:0] QUIET_CYC =
    CNT_W'((QUIET_NS * NS_FS + CLK_FS - 1) / CLK_FS);
  localparam logic [CNT_W-1:0] WAKE_GAP_MIN_CYC =
    CNT_W'((WAKE_GAP_MIN_NS * NS_FS + CLK_FS - 1) / CLK_FS);
  localparam logic [CNT_W-1:0] WAKE_GAP_MAX_CYC =
    CNT_W'((WAKE_GAP_MAX_NS * NS_FS) / CLK_FS);
  localparam logic [CNT_W-1:0] ALIGN_WAIT_CYC =
    CNT_W'((longint'(ALIGN_WAIT_DW) * DWORD_UI * UI_FS) / CLK_FS);

  // ==========================================================
  // rates and reset values
  localparam logic [1:0] RATE_GEN3 = 2'h2;
  localparam logic [1:0] RATE_MIN  = 2'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       vld;
    logic       is_align;
  } oobx_rx_t;

  typedef struct packed {
    logic       burst;
    logic       align;
    logic       sync;
    logic [1:0] rate;
  } oobx_tx_t;

  typedef enum logic [2:0] {
    S_CINIT, S_WAIT_WAKE, S_WAKE_TX, S_ALIGN, S_SYNC, S_UP, S_ERR, S_RESET
  } oobx_state_t;

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] idle;
    logic [2:0]       cnt;
    logic             det;
  } oobx_det_st_t;

  typedef struct packed {
    logic             s1;
    logic             s2;
    oobx_state_t      st;
    oobx_tx_t         tx;
    logic             rst_n;
    logic             up;
    logic             err;
    logic [CNT_W-1:0] tmr;
    logic [2:0]       nleft;
    logic             burst_ph;
    logic             seen;
    logic [1:0]       run;
  } oobx_st_t;

endpackage : oobx_pkg

// file: verilog/oobx_det.sv
/*
  Burst train detector: counts bursts whose spacing lies inside a window.
  Assumes a line level already synchronised to core_clk.
*/
`timescale 1ns/100ps
module oobx_det #(
  parameter logic [oobx_pkg::CNT_W-1:0] GAP_MIN = oobx_pkg::RST_GAP_MIN_CYC,
  parameter logic [oobx_pkg::CNT_W-1:0] GAP_MAX = oobx_pkg::RST_GAP_MAX_CYC,
  parameter int                         NBURST  = oobx_pkg::DET_BURSTS
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // line
  input  wire logic line,
  // result
  output logic      det
);

  // ==========================================================
  // state
  oobx_pkg::oobx_det_st_t s_r;
  oobx_pkg::oobx_det_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = line;
    if (line) begin
      s_nxt.idle = '0;
      if (!s_r.prev) begin
        if (s_r.cnt == 3'h0) begin
          // first burst after a long quiet: no spacing to check yet
          s_nxt.cnt = 3'h1;
        end else if (s_r.idle >= GAP_MIN && s_r.idle <= GAP_MAX) begin
          if (s_r.cnt != 3'h7) begin
            s_nxt.cnt = s_r.cnt + 3'h1;
          end
          if (32'(s_r.cnt) + 1 >= NBURST) begin
            s_nxt.det = 1'b1;
          end
        end else begin
          // spacing outside the window restarts the train
          s_nxt.cnt = 3'h1;
          s_nxt.det = 1'b0;
        end
      end
    end else begin
      if (s_r.idle != '1) begin
        s_nxt.idle = s_r.idle + 1'b1;
      end
      // long quiet: either a bad gap or the end of the signal
      if (s_r.idle > GAP_MAX) begin
        s_nxt.cnt = 3'h0;
        s_nxt.det = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign det = s_r.det;

endmodule : oobx_det

// file: verilog/oobx_link_init.sv
/*
  Device-side out-of-band link initialisation: reset and wake detection,
  COMINIT and COMWAKE transmission, rate stepping on ALIGN, SYNC and link-up.
  Assumes an analogue squelch level on rx_oob (asynchronous), a phy that
  turns tx_burst into ALIGN bursts, and a link layer that classifies
  received primitives on core_clk.
*/
`timescale 1ns/100ps
module oobx_link_init #(
  parameter logic [oobx_pkg::CNT_W-1:0] ALIGN_WAIT_CYC = oobx_pkg::ALIGN_WAIT_CYC,
  parameter logic [1:0]                 RATE_MAX       = oobx_pkg::RATE_GEN3
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // receive side
  input  wire logic               rx_oob,
  input  oobx_pkg::oobx_rx_t      rx_prim,
  // device side control
  input  wire logic               cominit_req,
  input  wire logic               dev_ready,
  // transmit side
  output oobx_pkg::oobx_tx_t      tx_ctl,
  // status
  output logic                    dev_rst_n,
  output logic                    link_up,
  output logic                    link_err
);

  // ==========================================================
  // state and detectors
  oobx_pkg::oobx_st_t s_r;
  oobx_pkg::oobx_st_t s_nxt;
  logic               rst_det;
  logic               wake_det;

  oobx_det #(
    .GAP_MIN (oobx_pkg::RST_GAP_MIN_CYC),
    .GAP_MAX (oobx_pkg::RST_GAP_MAX_CYC),
    .NBURST  (oobx_pkg::DET_BURSTS)
  ) u_rst_det (
    .core_clk (core_clk),
    .nrst     (nrst),
    .line     (s_r.s2),
    .det      (rst_det)
  );

  oobx_det #(
    .GAP_MIN (oobx_pkg::WAKE_GAP_MIN_CYC),
    .GAP_MAX (oobx_pkg::WAKE_GAP_MAX_CYC),
    .NBURST  (oobx_pkg::DET_BURSTS)
  ) u_wake_det (
    .core_clk (core_clk),
    .nrst     (nrst),
    .line     (s_r.s2),
    .det      (wake_det)
  );

  // ==========================================================
  // burst train sequencer, shared by COMINIT and COMWAKE
  function automatic oobx_pkg::oobx_st_t seq_step(
    input oobx_pkg::oobx_st_t     s,
    input logic [oobx_pkg::CNT_W-1:0] gap
  );
    oobx_pkg::oobx_st_t n;
    n = s;
    if (s.tmr != '0) begin
      n.tmr = s.tmr - 1'b1;
    end else if (s.burst_ph) begin
      n.tx.burst = 1'b0;
      n.burst_ph = 1'b0;
      n.nleft    = s.nleft - 3'h1;
      if (s.nleft == 3'h1) begin
        n.tmr = oobx_pkg::QUIET_CYC - 1'b1;
      end else begin
        n.tmr = gap - 1'b1;
      end
    end else if (s.nleft != 3'h0) begin
      // burst content is chosen by the phy: four Gen1 ALIGN dwords
      n.tx.burst = 1'b1;
      n.burst_ph = 1'b1;
      n.tmr      = oobx_pkg::BURST_CYC - 1'b1;
    end
    return n;
  endfunction : seq_step

  function automatic logic seq_done(input oobx_pkg::oobx_st_t s);
    return (s.tmr == '0) && !s.burst_ph && (s.nleft == 3'h0);
  endfunction : seq_done

  // ==========================================================
  // next state
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = rx_oob;
    s_nxt.s2 = s_r.s1;

    if (rst_det) begin
      // reset wins over everything, including a pending COMINIT request
      s_nxt.st       = oobx_pkg::S_RESET;
      s_nxt.rst_n    = 1'b0;
      s_nxt.tx       = '0;
      s_nxt.tx.rate  = RATE_MAX;
      s_nxt.up       = 1'b0;
      s_nxt.err      = 1'b0;
      s_nxt.burst_ph = 1'b0;
      s_nxt.tmr      = '0;
    end else if (cominit_req && s_r.st != oobx_pkg::S_CINIT &&
                 s_r.st != oobx_pkg::S_RESET) begin
      s_nxt.st       = oobx_pkg::S_CINIT;
      s_nxt.tx       = '0;
      s_nxt.tx.rate  = RATE_MAX;
      s_nxt.up       = 1'b0;
      s_nxt.err      = 1'b0;
      s_nxt.nleft    = 3'(oobx_pkg::TX_BURSTS);
      s_nxt.burst_ph = 1'b0;
      s_nxt.tmr      = '0;
    end else begin
      case (s_r.st)
        oobx_pkg::S_RESET: begin
          // detector has seen the long quiet: COMRESET is over
          s_nxt.st       = oobx_pkg::S_CINIT;
          s_nxt.rst_n    = 1'b1;
          s_nxt.nleft    = 3'(oobx_pkg::TX_BURSTS);
          s_nxt.burst_ph = 1'b0;
          s_nxt.tmr      = '0;
        end
        oobx_pkg::S_CINIT: begin
          // same gap as COMRESET; s_nxt keeps the synchroniser sampling,
          // so a COMRESET that arrives mid-train is still seen
          s_nxt = seq_step(s_nxt, oobx_pkg::GAP_CYC);
          if (seq_done(s_r)) begin
            s_nxt.st   = oobx_pkg::S_WAIT_WAKE;
            s_nxt.seen = 1'b0;
          end
        end
        oobx_pkg::S_WAIT_WAKE: begin
          if (wake_det) begin
            s_nxt.seen = 1'b1;
          end else if (s_r.seen) begin
            // host wake ended; no transmitter calibration here
            s_nxt.st       = oobx_pkg::S_WAKE_TX;
            s_nxt.nleft    = 3'(oobx_pkg::TX_BURSTS);
            s_nxt.burst_ph = 1'b0;
            s_nxt.tmr      = '0;
          end
        end
        oobx_pkg::S_WAKE_TX: begin
          s_nxt = seq_step(s_nxt, oobx_pkg::WAKE_GAP_CYC);
          if (seq_done(s_r)) begin
            s_nxt.st       = oobx_pkg::S_ALIGN;
            s_nxt.tx.align = 1'b1;
            s_nxt.tx.rate  = RATE_MAX;
            s_nxt.tmr      = ALIGN_WAIT_CYC - 1'b1;
            s_nxt.seen     = 1'b0;
          end
        end
        oobx_pkg::S_ALIGN: begin
          if (rx_prim.vld && rx_prim.is_align) begin
            s_nxt.seen = 1'b1;
          end
          if (s_r.seen && dev_ready) begin
            s_nxt.st       = oobx_pkg::S_SYNC;
            s_nxt.tx.align = 1'b0;
            s_nxt.tx.sync  = 1'b1;
            s_nxt.run      = 2'h0;
          end else if (s_r.seen) begin
            s_nxt.tmr = s_r.tmr;
          end else if (s_r.tmr != '0) begin
            s_nxt.tmr = s_r.tmr - 1'b1;
          end else if (!(rx_prim.vld && rx_prim.is_align)) begin
            if (s_r.tx.rate > oobx_pkg::RATE_MIN) begin
              s_nxt.tx.rate = s_r.tx.rate - 2'h1;
              s_nxt.tmr     = ALIGN_WAIT_CYC - 1'b1;
            end else begin
              s_nxt.st       = oobx_pkg::S_ERR;
              s_nxt.err      = 1'b1;
              s_nxt.tx.align = 1'b0;
            end
          end
        end
        oobx_pkg::S_SYNC: begin
          if (rx_prim.vld) begin
            if (rx_prim.is_align) begin
              s_nxt.run = 2'h0;
            end else if (32'(s_r.run) + 1 >= oobx_pkg::NONALIGN_RUN) begin
              s_nxt.st = oobx_pkg::S_UP;
              s_nxt.up = 1'b1;
            end else begin
              s_nxt.run = s_r.run + 2'h1;
            end
          end
        end
        oobx_pkg::S_UP: begin
          // idle link keeps sending SYNC until the link layer takes over
          s_nxt.up = 1'b1;
        end
        oobx_pkg::S_ERR: begin
          // left only through COMRESET or a COMINIT request
          s_nxt.err = 1'b1;
        end
        default: begin
          s_nxt.st = oobx_pkg::S_CINIT;
        end
      endcase
    end
  end

  // ==========================================================
  // registers; power-up enters with COMINIT, as a late-starting device
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r          <= '0;
      s_r.st       <= oobx_pkg::S_CINIT;
      s_r.tx.rate  <= oobx_pkg::RATE_GEN3;
      s_r.rst_n    <= 1'b1;
      s_r.nleft    <= 3'(oobx_pkg::TX_BURSTS);
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign tx_ctl    = s_r.tx;
  assign dev_rst_n = s_r.rst_n;
  assign link_up   = s_r.up;
  assign link_err  = s_r.err;

endmodule : oobx_link_init

// file: testbench/oobx_link_init_props.sv
/*
  Port-level assertions for the out-of-band link initialisation block.
  Assumes the single core_clk domain and the nrst reset of the design.
*/
`timescale 1ns/100ps
module oobx_link_init_props #(
  parameter logic [oobx_pkg::CNT_W-1:0] ALIGN_WAIT_CYC = oobx_pkg::ALIGN_WAIT_CYC,
  parameter logic [1:0]                 RATE_MAX       = oobx_pkg::RATE_GEN3
) (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    nrst,
  // inputs
  input wire oobx_pkg::oobx_rx_t      rx_prim,
  input wire logic                    dev_ready,
  // outputs
  input wire oobx_pkg::oobx_tx_t      tx_ctl,
  input wire logic                    dev_rst_n,
  input wire logic                    link_up,
  input wire logic                    link_err
);
  // ==========================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_rst_quiets_tx: assert property (!dev_rst_n |->
      !tx_ctl.burst && !tx_ctl.align && !link_up)
    else $error("transmit or link active during device reset");
  a_rst_holds: assert property ($fell(dev_rst_n) |-> !dev_rst_n[*8])
    else $error("device reset released too early");
  // a reset mid-burst legally cuts the burst short
  a_burst_len: assert property (disable iff (!nrst || !dev_rst_n)
      $rose(tx_ctl.burst) |-> tx_ctl.burst[*8] ##1 tx_ctl.burst[*3] ##1 !tx_ctl.burst)
    else $error("burst length not 11 cycles");
  a_align_start: assert property ($rose(tx_ctl.align) |-> tx_ctl.rate == RATE_MAX)
    else $error("align stream not at top rate");
  a_rate_step: assert property (tx_ctl.align && $past(tx_ctl.align)
      && tx_ctl.rate != $past(tx_ctl.rate) |-> tx_ctl.rate == $past(tx_ctl.rate) - 2'h1)
    else $error("rate did not step down by one");
  a_err_state: assert property (link_err |-> !tx_ctl.align && !tx_ctl.sync && !link_up)
    else $error("error state still transmitting");
  a_sync_needs_align: assert property ($rose(tx_ctl.sync) |-> $past(tx_ctl.align)
      && $past(dev_ready))
    else $error("sync without ready align phase");
  a_up_after_run: assert property ($rose(link_up) |-> $past(rx_prim.vld)
      && !$past(rx_prim.is_align) && tx_ctl.sync)
    else $error("link up without non-align primitive");
endmodule : oobx_link_init_props

bind oobx_link_init oobx_link_init_props #(
  .ALIGN_WAIT_CYC(ALIGN_WAIT_CYC), .RATE_MAX(RATE_MAX)
) u_props (
  .core_clk(core_clk), .nrst(nrst), .rx_prim(rx_prim), .dev_ready(dev_ready),
  .tx_ctl(tx_ctl), .dev_rst_n(dev_rst_n), .link_up(link_up), .link_err(link_err)
);

// file: testbench/oobx_host_model.sv
/*
  Behavioural host: sends out-of-band bursts and received primitives.
  Assumes the bench calls its tasks; drives at the falling edge.
*/
`timescale 1ns/100ps
module oobx_host_model (
  // clock
  input wire logic                    core_clk,
  // device transmit side; only read for the rate echo
  input wire oobx_pkg::oobx_tx_t      tx_ctl,
  // device receive side
  output logic                        rx_oob,
  output oobx_pkg::oobx_rx_t          rx_prim
);
  // rate a locked host answers at: the rate it hears
  logic [1:0]                         echo_rate;

  // d10.2 filler is no primitive, so vld stays low between primitives
  initial begin
    rx_oob = 1'b0;
    rx_prim = '0;
  end

  always @(posedge core_clk) if (tx_ctl.align === 1'b1) echo_rate <= tx_ctl.rate;

  // ==========================================
  // burst trains; comreset uses six bursts, comwake after cominit
  // trains never look at tx_ctl: the host ignores the device meanwhile
  task automatic send_train(input int n, input int gap);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge core_clk);
      rx_oob = 1'b1;
      repeat (11) @(negedge core_clk);
      rx_oob = 1'b0;
      repeat ((i == n - 1) ? 53 : gap - 1) @(negedge core_clk);
    end
  endtask : send_train

  // one primitive; the line then shows the inverse of the last type
  task automatic send_prim(input logic a);
    @(negedge core_clk);
    rx_prim = '{vld: 1'b1, is_align: a};
    @(negedge core_clk);
    rx_prim = '{vld: 1'b0, is_align: ~a};
  endtask : send_prim
endmodule : oobx_host_model

// file: testbench/sata_oob_link_init_bench.sv
/*
  Self-checking bench for the link initialisation block with a host model.
  Assumes a short align wait of 50 cycles to keep the run brief.
*/
`timescale 1ns/100ps
module sata_oob_link_init_bench;
  logic               core_clk, nrst, rx_oob, cominit_req, dev_ready;
  logic               dev_rst_n, link_up, link_err, rst_seen;
  oobx_pkg::oobx_rx_t rx_prim;
  oobx_pkg::oobx_tx_t tx_ctl;
  int                 fail_count, num_checks, cyc, k, r, run;
  logic               exp_up;

  oobx_link_init #(.ALIGN_WAIT_CYC(16'h0032), .RATE_MAX(2'h2)) dut (
    .core_clk(core_clk), .nrst(nrst), .rx_oob(rx_oob), .rx_prim(rx_prim),
    .cominit_req(cominit_req), .dev_ready(dev_ready), .tx_ctl(tx_ctl),
    .dev_rst_n(dev_rst_n), .link_up(link_up), .link_err(link_err));
  oobx_host_model host (.core_clk(core_clk), .tx_ctl(tx_ctl), .rx_oob(rx_oob), .rx_prim(rx_prim));

  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // six bursts of 11 cycles, given gap, then quiet
  task automatic watch_train(input int gap);
    int n, c;
    c = 0;
    while (tx_ctl.burst !== 1'b1 && c < 3000) begin
      @(negedge core_clk);
      c++;
    end
    for (n = 0; n < 6; n++) begin
      c = 0;
      while (tx_ctl.burst === 1'b1 && c < 40) begin
        @(negedge core_clk);
        c++;
      end
      check(16'(c), 16'h000b);
      c = 0;
      while (tx_ctl.burst !== 1'b1 && c < 60) begin
        @(negedge core_clk);
        c++;
      end
      check(16'(c), (n == 5) ? 16'h003c : 16'(gap));
    end
  endtask : watch_train

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, well above the expected few thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  always @(negedge core_clk) if (dev_rst_n === 1'b0) rst_seen <= 1'b1;

  // ==========================================
  // scenarios
  initial begin
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    rst_seen = 1'b0;
    nrst = 1'b0;
    cominit_req = 1'b0;
    dev_ready = 1'b0;
    r = $urandom(32'hf0a6);
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    watch_train(32);
    fork
      host.send_train(6, 11);
      watch_train(11);
    join
    check(16'({tx_ctl.align, tx_ctl.rate}), 16'h0006);
    for (r = 2; r >= 0; r--) begin
      k = 0;
      while (tx_ctl.rate === 2'(r) && tx_ctl.align === 1'b1 && k < 200) begin
        @(negedge core_clk);
        k++;
      end
      check(16'(k <= 52 && k >= ((r == 2) ? 30 : 48)), 16'h0001);
    end
    check(16'({link_err, tx_ctl.align}), 16'h0002);
    @(negedge core_clk);
    cominit_req = 1'b1;
    @(negedge core_clk);
    cominit_req = 1'b0;
    check(16'(link_err), 16'h0000);
    watch_train(32);
    fork
      host.send_train(6, 11);
      watch_train(11);
    join
    repeat ($urandom_range(20)) @(negedge core_clk);
    host.send_prim(1'b1);
    check(16'(host.echo_rate), 16'h0002);
    repeat (3) @(negedge core_clk);
    check(16'(tx_ctl.sync), 16'h0000);
    dev_ready = 1'b1;
    repeat (2) @(negedge core_clk);
    check(16'({tx_ctl.sync, tx_ctl.align, tx_ctl.rate}), 16'h000a);
    run = 0;
    exp_up = 1'b0;
    k = 0;
    while (!exp_up && k < 30) begin
      r = ($urandom_range(3) == 0);
      host.send_prim(r[0]);
      run = r ? 0 : run + 1;
      exp_up = (run >= 3);
      @(negedge core_clk);
      check(16'(link_up), 16'(exp_up));
      repeat ($urandom_range(2)) @(negedge core_clk);
      k++;
    end
    rst_seen = 1'b0;
    host.send_train(3, 32);
    check(16'({rst_seen, link_up}), 16'h0001);
    host.send_train(6, 15);
    check(16'({rst_seen, link_up}), 16'h0001);
    host.send_train(6, 60);
    check(16'({rst_seen, link_up}), 16'h0001);
    host.send_train(6, 32);
    check(16'({rst_seen, link_up}), 16'h0002);
    watch_train(32);
    complete_run();
  end
endmodule : sata_oob_link_init_bench
